/* rtl/dac_load_pkg.sv */
// Constants for the serial DAC load port
package dac_load_pkg;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned CNT_W     = 5;
  localparam logic [CNT_W-1:0]  BITS_PER_WORD = 5'h10;
  localparam logic [CNT_W-1:0]  CNT_ZERO      = 5'h00;
  localparam logic [WORD_W-1:0] WORD_RESET    = 16'h0000;
  localparam logic [1:0]        SYNC_RESET    = 2'h3;
  // Fill levels of the two-entry word buffer
  localparam logic [1:0]        BUF_EMPTY     = 2'h0;
  localparam logic [1:0]        BUF_FULL      = 2'h2;
endpackage : dac_load_pkg

/* rtl/serial_dac_load_port.sv */
// Serial load port of a single-channel 16-bit DAC, oversampled by clock_i
`timescale 1ns/1ps
module serial_dac_load_port
  import dac_load_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // Serial link pins
  input  wire logic              frame_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdata_i,
  input  wire logic              async_load_n_i,
  // DAC register and lost-word flag
  output logic      [WORD_W-1:0] dac_word_o,
  output logic                   dac_update_o,
  output logic                   word_lost_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage only feeds second stage
  logic [1:0] frm_s1_q, frm_s2_q;
  logic [1:0] clk_s1_q, clk_s2_q;
  logic [1:0] dat_s1_q, dat_s2_q;
  logic [1:0] ld_s1_q,  ld_s2_q;
  logic       frm_prev_q, clk_prev_q, ld_prev_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frm_s1_q   <= SYNC_RESET;
      frm_s2_q   <= SYNC_RESET;
      clk_s1_q   <= 2'h0;
      clk_s2_q   <= 2'h0;
      dat_s1_q   <= 2'h0;
      dat_s2_q   <= 2'h0;
      ld_s1_q    <= SYNC_RESET;
      ld_s2_q    <= SYNC_RESET;
      frm_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
      ld_prev_q  <= 1'b1;
    end else begin
      frm_s1_q   <= {1'b0, frame_n_i};
      frm_s2_q   <= frm_s1_q;
      clk_s1_q   <= {1'b0, sclk_i};
      clk_s2_q   <= clk_s1_q;
      dat_s1_q   <= {1'b0, sdata_i};
      dat_s2_q   <= dat_s1_q;
      ld_s1_q    <= {1'b0, async_load_n_i};
      ld_s2_q    <= ld_s1_q;
      frm_prev_q <= frm_s2_q[0];
      clk_prev_q <= clk_s2_q[0];
      ld_prev_q  <= ld_s2_q[0];
    end
  end

  logic frm_n, sclk, sdat, ld_n;
  logic sclk_rise, frame_end, ld_fall;
  assign frm_n     = frm_s2_q[0];
  assign sclk      = clk_s2_q[0];
  assign sdat      = dat_s2_q[0];
  assign ld_n      = ld_s2_q[0];
  assign sclk_rise = sclk && !clk_prev_q;
  assign frame_end = frm_n && !frm_prev_q;
  assign ld_fall   = !ld_n && ld_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Shift register and bit count
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              full_word;

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    if (frm_n) begin
      cnt_d = CNT_ZERO;
    end else if (sclk_rise) begin
      shift_d = {shift_q[WORD_W-2:0], sdat};
      // Saturate so that an overlong frame stays invalid
      if (cnt_q <= BITS_PER_WORD) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= WORD_RESET;
      cnt_q   <= CNT_ZERO;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  assign full_word = (cnt_q == BITS_PER_WORD);

  //////////////////////////////////////////////////////////////////////////////
  // Input register: word captured at frame end, pushed to buffer
  word_buf_if buf_in ();
  logic [WORD_W-1:0] in_reg_q, in_reg_d;
  logic              push_q, push_d;
  logic              lost_q, lost_d;

  always_comb begin
    in_reg_d = in_reg_q;
    push_d   = 1'b0;
    lost_d   = 1'b0;
    if (frame_end && full_word) begin
      in_reg_d = shift_q;
      push_d   = 1'b1;
      lost_d   = !buf_in.ready;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_reg_q <= WORD_RESET;
      push_q   <= 1'b0;
      lost_q   <= 1'b0;
    end else begin
      in_reg_q <= in_reg_d;
      push_q   <= push_d;
      lost_q   <= lost_d;
    end
  end

  assign buf_in.data  = in_reg_q;
  assign buf_in.valid = push_q;
  assign word_lost_o  = lost_q;

  logic [WORD_W-1:0] pend_word;
  logic              pend_valid, pend_ready;

  word_buf2 u_buf (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_if       (buf_in),
    .out_data_o  (pend_word),
    .out_valid_o (pend_valid),
    .out_ready_i (pend_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // DAC register update
  logic [WORD_W-1:0] dac_q, dac_d;
  logic              upd_q, upd_d;
  logic              load_now;

  assign load_now   = !ld_n || ld_fall;
  // Held words wait in the buffer while the load input is idle high
  assign pend_ready = load_now;

  always_comb begin
    dac_d = dac_q;
    upd_d = 1'b0;
    if (pend_valid && load_now) begin
      dac_d = pend_word;
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_q <= WORD_RESET;
      upd_q <= 1'b0;
    end else begin
      dac_q <= dac_d;
      upd_q <= upd_d;
    end
  end

  assign dac_word_o   = dac_q;
  assign dac_update_o = upd_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // idle frame holds shifter
  property p_idle_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      frm_n |=> (shift_q == $past(shift_q)) && (cnt_q == CNT_ZERO);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("shifter moved while idle");

  property p_shift;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!frm_n && sclk_rise) |=> shift_q[0] == $past(sdat);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not sampled");

  property p_msb;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!frm_n && sclk_rise) |=> shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]);
  endproperty
  a_msb: assert property (p_msb) else $error("wrong shift direction");

  property p_push;
    @(posedge clock_i) disable iff (!rst_n_i)
      (frame_end && full_word) |=> push_q && in_reg_q == $past(shift_q);
  endproperty
  a_push: assert property (p_push) else $error("full word not pushed");

  property p_short;
    @(posedge clock_i) disable iff (!rst_n_i)
      (frame_end && !full_word) |=> !push_q;
  endproperty
  a_short: assert property (p_short) else $error("bad frame pushed");

  property p_load;
    @(posedge clock_i) disable iff (!rst_n_i)
      (pend_valid && ld_fall) |=> dac_update_o && dac_word_o == $past(pend_word);
  endproperty
  a_load: assert property (p_load) else $error("load did not update");

  property p_tied;
    @(posedge clock_i) disable iff (!rst_n_i)
      (frame_end && full_word && !ld_n) ##1 !ld_n |-> ##[1:2] dac_update_o;
  endproperty
  a_tied: assert property (p_tied) else $error("tied load missed update");

  property p_count;
    @(posedge clock_i) disable iff (!rst_n_i)
      cnt_q <= BITS_PER_WORD + 5'h01;
  endproperty
  a_count: assert property (p_count) else $error("bit count out of range");

  property p_upd_cause;
    @(posedge clock_i) disable iff (!rst_n_i)
      dac_update_o |-> $past(pend_valid);
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("update without word");
endmodule : serial_dac_load_port

/* rtl/word_buf2.sv */
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
module word_buf2
  import dac_load_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // Filling side
  word_buf_if.dst                in_if,
  // Draining side
  output logic      [WORD_W-1:0] out_data_o,
  output logic                   out_valid_o,
  input  wire logic              out_ready_i
);
  logic [WORD_W-1:0] mem_q [2];
  logic [WORD_W-1:0] mem_d [2];
  logic              wr_q, wr_d, rd_q, rd_d;
  logic [1:0]        cnt_q, cnt_d;
  logic              push, pop;

  // Pointer and storage next state
  always_comb begin
    push     = in_if.valid && (cnt_q != BUF_FULL);
    pop      = (cnt_q != BUF_EMPTY) && out_ready_i;
    mem_d    = mem_q;
    wr_d     = wr_q;
    rd_d     = rd_q;
    cnt_d    = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_if.data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= WORD_RESET;
      mem_q[1] <= WORD_RESET;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= BUF_EMPTY;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Ready is honest full; data comes from storage flops
  assign in_if.ready = (cnt_q != BUF_FULL);
  assign out_valid_o = (cnt_q != BUF_EMPTY);
  assign out_data_o  = mem_q[rd_q];

  property p_no_overflow;
    @(posedge clock_i) disable iff (!rst_n_i)
      cnt_q <= BUF_FULL;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer count above depth");
endmodule : word_buf2

/* rtl/word_buf_if.sv */
// Valid/ready word channel between the frame logic and the two-entry buffer
`timescale 1ns/1ps
interface word_buf_if;
  logic [15:0] data;
  logic        valid;
  logic        ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface : word_buf_if

/* tb/dac_host_model.sv */
// Serial host model driving the DAC load port pins
`timescale 1ns/1ps
module dac_host_model (
  // Clock
  input  wire logic clock_i,
  // Link pins
  output logic      frame_n_o,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      async_load_n_o
);
  // Idle link, load tied low
  initial begin
    frame_n_o      = 1'b1;
    sclk_o         = 1'b0;
    sdata_o        = 1'b0;
    async_load_n_o = 1'b0;
  end

  // Pins move just after a clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_clk

  // v high pulls the load pin low; v low holds it high while shifting
  task automatic set_load(input logic v);
    async_load_n_o = ~v;
  endtask : set_load

  // framed word, MSB first; n other than 16 makes a bad frame
  task automatic send(input logic [15:0] w, input int n);
    frame_n_o = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdata_o = (i >= 0) ? w[i[3:0]] : ~sdata_o;
      wait_clk(4);
      sclk_o = 1'b1;
      wait_clk(4);
      sclk_o = 1'b0;
    end
    wait_clk(2);
    frame_n_o = 1'b1;
    // Released data line must not look stale
    sdata_o = ~sdata_o;
    wait_clk(4);
  endtask : send

  // clock and data toggled with frame high
  task automatic noise(input int n);
    repeat (n) begin
      sdata_o = ~sdata_o;
      sclk_o  = 1'b1;
      wait_clk(4);
      sclk_o  = 1'b0;
      wait_clk(4);
    end
  endtask : noise
endmodule : dac_host_model

/* tb/tb.sv */
// Self-checking bench for the serial DAC load port
`timescale 1ns/1ps
module tb;
  import dac_load_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  // Nets driven by the host model and the design
  wire logic              frame_n;
  wire logic              sclk;
  wire logic              sdata;
  wire logic              load_n;
  wire logic [WORD_W-1:0] dac_word;
  wire logic              dac_update;
  wire logic              word_lost;
  logic [WORD_W-1:0] exp_q[$];
  int                num_errors = 0;
  int                check_count = 0;
  int                lost_seen = 0;
  int                seed = 32'h51276812;

  // 50 MHz clock
  always #10 clock = ~clock;

  dac_host_model i_dac_host_model (
    .clock_i        (clock),
    .frame_n_o      (frame_n),
    .sclk_o         (sclk),
    .sdata_o        (sdata),
    .async_load_n_o (load_n)
  );

  serial_dac_load_port i_serial_dac_load_port (
    .clock_i        (clock),
    .rst_n_i        (rst_n),
    .frame_n_i      (frame_n),
    .sclk_i         (sclk),
    .sdata_i        (sdata),
    .async_load_n_i (load_n),
    .dac_word_o     (dac_word),
    .dac_update_o   (dac_update),
    .word_lost_o    (word_lost)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected 0x%h got 0x%h", $time, e, g);
    end
  endtask : check_word

  task automatic check_val(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected 0x%h got 0x%h", $time, e, g);
    end
  endtask : check_val

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Each update takes the oldest expected word; a surprise update is an error
  // Sampled on the falling edge, where registered outputs have settled
  always @(negedge clock) begin
    if (dac_update === 1'b1) begin
      if (exp_q.size() == 0)
        check_val(0, 1);
      else
        check_word(exp_q.pop_front(), dac_word);
    end
    if (word_lost === 1'b1)
      lost_seen++;
  end

  // Main sequence
  initial begin
    logic [WORD_W-1:0] w;
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1'b1;
    i_dac_host_model.wait_clk(4);
    // Boundary and random words back to back, load tied low
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : (k == 2) ? 16'h8001 : 16'($random(seed));
      exp_q.push_back(w);
      i_dac_host_model.send(w, 16);
    end
    // Short and long frames must be dropped, counts restart per frame
    i_dac_host_model.send(16'h1234, 15);
    i_dac_host_model.send(16'h4321, 17);
    i_dac_host_model.noise(5);
    exp_q.push_back(16'h5aa5);
    i_dac_host_model.send(16'h5aa5, 16);
    // Load pin held high: two words wait, the third overflows the buffer
    i_dac_host_model.set_load(1'b0);
    for (int k = 0; k < 3; k++) begin
      w = 16'($random(seed));
      if (k < 2)
        exp_q.push_back(w);
      i_dac_host_model.send(w, 16);
    end
    i_dac_host_model.wait_clk(10);
    check_val(2, exp_q.size());
    check_val(1, lost_seen);
    // Dropping the load pin releases the waiting words in order
    i_dac_host_model.set_load(1'b1);
    i_dac_host_model.wait_clk(20);
    check_val(0, exp_q.size());
    check_val(1, lost_seen);
    give_verdict();
  end

  // Watchdog, far beyond the expected run of about 1700 cycles
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule : tb
